// ==== rtl/dss_pkg.sv ====
// Constants and carrier types for the dual conversion sequencer.
// Assumes a single synchronous clock domain and an external trigger source.
package dss_pkg;
	localparam int DSS_NBITS  = 18;
	localparam int DSS_STAGES = 19;
	localparam logic [DSS_STAGES-1:0] DSS_SEQ_RST = 19'h00000;
	localparam logic [DSS_NBITS-1:0]  DSS_BITS_RST = 18'h00000;

	typedef enum logic [1:0] {
		DSS_TRACK,
		DSS_CONVERT
	} dss_state_e;

	// Per-channel switch drive: main weighting and trim switches
	typedef struct packed {
		logic [DSS_NBITS-1:0] capacitor_weighting_dac;
		logic [DSS_NBITS-1:0] trim_correction_dac;
	} dss_switch_s;
endpackage

// ==== rtl/dss_sequencer.sv ====
// Dual-channel successive approximation sequencer, logic side only.
// Assumes trigger and comparator inputs are synchronous to sys_clk_i.
// The analog switches, comparators and trim network sit outside this file;
// the switch drive outputs here only say which bits are switched in.
`timescale 1ns/10ps
module dss_sequencer
	import dss_pkg::*;
#(
	parameter int NBITS = DSS_NBITS
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rstn_i,
	input  wire logic              convert_i,
	input  wire logic              cmp_left_keep_i,
	input  wire logic              cmp_right_keep_i,
	output logic                   hold_o,
	output logic                   autozero_o,
	output logic                   busy_o,
	output logic [NBITS:0]         stage_o,
	output dss_switch_s            left_switch_o,
	output dss_switch_s            right_switch_o,
	output logic                   left_serial_out_o,
	output logic                   right_serial_out_o,
	output logic                   data_valid_o
);

	// ***********************************************************
	// Trigger edge and mode state
	// ***********************************************************
	logic             conv_prev_q;
	logic             start;
	dss_state_e       state_q;
	logic [NBITS:0]   seq_q;
	logic [NBITS-1:0] left_bits_q;
	logic [NBITS-1:0] right_bits_q;
	logic [NBITS-1:0] trial_on;

	// Rising edge only; a held-high trigger never restarts
	assign start = convert_i & ~conv_prev_q & (state_q == DSS_TRACK);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			conv_prev_q <= 1'b0;
		end else begin
			conv_prev_q <= convert_i;
		end
	end

	// Track until trigger, convert until last stage retires
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= DSS_TRACK;
		end else begin
			unique case (state_q)
				DSS_TRACK: begin
					if (start) begin
						state_q <= DSS_CONVERT;
					end
				end
				DSS_CONVERT: begin
					if (seq_q[NBITS]) begin
						state_q <= DSS_TRACK;
					end
				end
			endcase
		end
	end

	// Hold and auto-zero shared by both channels, so sampling is co-phase
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_o     <= 1'b0;
			autozero_o <= 1'b1;
			busy_o     <= 1'b0;
		end else if (start) begin
			hold_o     <= 1'b1;
			autozero_o <= 1'b0;
			busy_o     <= 1'b1;
		end else if (state_q == DSS_CONVERT && seq_q[NBITS]) begin
			hold_o     <= 1'b0;
			autozero_o <= 1'b1;
			busy_o     <= 1'b0;
		end
	end

	// ***********************************************************
	// One-hot bit test sequencer
	// ***********************************************************
	// Stage 0 tests the MSB; stage NBITS is the final retire stage
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seq_q <= DSS_SEQ_RST;
		end else if (start) begin
			seq_q <= {{NBITS{1'b0}}, 1'b1};
		end else begin
			seq_q <= {seq_q[NBITS-1:0], 1'b0};
		end
	end

	assign stage_o = seq_q;

	// Bit k is trialled while stage k-1 is active
	// Shifted copy keeps the loop free of a negative index at k = 0
	assign trial_on = {seq_q[NBITS-2:0], 1'b0};

	// ***********************************************************
	// Decision latches, two banks in lockstep
	// ***********************************************************
	// Bit index NBITS-1 is MSB; stage k tests bit NBITS-1-k
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			left_bits_q  <= DSS_BITS_RST;
			right_bits_q <= DSS_BITS_RST;
		end else if (start) begin
			left_bits_q  <= DSS_BITS_RST;
			right_bits_q <= DSS_BITS_RST;
		end else begin
			for (int k = 0; k < NBITS; k++) begin
				if (seq_q[k]) begin
					left_bits_q[NBITS-1-k]  <= cmp_left_keep_i;
					right_bits_q[NBITS-1-k] <= cmp_right_keep_i;
				end
			end
		end
	end

	// Switch drive: trial bit forced on while its pulse is high, latch after
	// Registered from next-state terms so outputs come from flip-flops
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			left_switch_o  <= '0;
			right_switch_o <= '0;
		end else begin
			for (int k = 0; k < NBITS; k++) begin
				if (start) begin
					left_switch_o.capacitor_weighting_dac[NBITS-1-k]  <= (k == 0);
					left_switch_o.trim_correction_dac[NBITS-1-k]  <= (k == 0);
					right_switch_o.capacitor_weighting_dac[NBITS-1-k] <= (k == 0);
					right_switch_o.trim_correction_dac[NBITS-1-k] <= (k == 0);
				end else if (trial_on[k]) begin
					left_switch_o.capacitor_weighting_dac[NBITS-1-k]  <= 1'b1;
					left_switch_o.trim_correction_dac[NBITS-1-k]  <= 1'b1;
					right_switch_o.capacitor_weighting_dac[NBITS-1-k] <= 1'b1;
					right_switch_o.trim_correction_dac[NBITS-1-k] <= 1'b1;
				end else if (seq_q[k]) begin
					left_switch_o.capacitor_weighting_dac[NBITS-1-k]  <= cmp_left_keep_i;
					left_switch_o.trim_correction_dac[NBITS-1-k]  <= cmp_left_keep_i;
					right_switch_o.capacitor_weighting_dac[NBITS-1-k] <= cmp_right_keep_i;
					right_switch_o.trim_correction_dac[NBITS-1-k] <= cmp_right_keep_i;
				end
			end
		end
	end

	// ***********************************************************
	// Serial outputs
	// ***********************************************************
	// Decision appears one clock after strobe; MSB first, raw straight binary
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			left_serial_out_o  <= 1'b0;
			right_serial_out_o <= 1'b0;
			data_valid_o       <= 1'b0;
		end else begin
			data_valid_o       <= |seq_q[NBITS-1:0];
			left_serial_out_o  <= |(seq_q[NBITS-1:0] & {NBITS{cmp_left_keep_i}});
			right_serial_out_o <= |(seq_q[NBITS-1:0] & {NBITS{cmp_right_keep_i}});
		end
	end

	// ***********************************************************
	// Assertion helpers
	// ***********************************************************
	// Length of the current busy run, counted rather than repeated
	// Saturates so a stuck busy cannot wrap back to the expected length
	logic [4:0] busy_run_q;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_run_q <= 5'h00;
		end else if (!busy_o) begin
			busy_run_q <= 5'h00;
		end else if (busy_run_q != 5'h1f) begin
			busy_run_q <= busy_run_q + 5'h01;
		end
	end

	// ***********************************************************
	// Assertions
	// ***********************************************************
	// Trigger edge puts both channels into hold at once
	property p_hold_on_start;
		@(posedge sys_clk_i) disable iff (!rstn_i) start |=> hold_o && !autozero_o;
	endproperty
	a_hold_on_start: assert property (p_hold_on_start) else $error("hold not entered");

	// Auto-zero closed exactly while tracking
	property p_az_opposite;
		@(posedge sys_clk_i) disable iff (!rstn_i) autozero_o == !hold_o;
	endproperty
	a_az_opposite: assert property (p_az_opposite) else $error("autozero while holding");

	// Busy lasts one cycle per stage, MSB test through retire
	property p_conv_len;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			$fell(busy_o) |-> busy_run_q == 5'(NBITS + 1);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	// Retire stage hands both channels back to tracking
	property p_retire;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			seq_q[NBITS] |=> !hold_o && autozero_o && !busy_o;
	endproperty
	a_retire: assert property (p_retire) else $error("tracking not resumed");

	// Never more than one stage pulse
	property p_onehot;
		@(posedge sys_clk_i) disable iff (!rstn_i) $onehot0(seq_q);
	endproperty
	a_onehot: assert property (p_onehot) else $error("sequencer not one-hot");

	// Stage pulses run only while busy
	property p_seq_idle;
		@(posedge sys_clk_i) disable iff (!rstn_i) busy_o == (|seq_q);
	endproperty
	a_seq_idle: assert property (p_seq_idle) else $error("stage outside conversion");

	// Stage order: MSB test first, retire stage last
	property p_msb_first;
		@(posedge sys_clk_i) disable iff (!rstn_i) start |=> seq_q[0] ##18 seq_q[NBITS];
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("stage order wrong");

	// Trigger edge while busy is ignored, no restart
	property p_refuse;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			busy_o && convert_i && !conv_prev_q && !seq_q[0] |=> !seq_q[0];
	endproperty
	a_refuse: assert property (p_refuse) else $error("restarted while busy");

	// MSB decision latched in the left bank as stage 0 ends
	property p_latch_left;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			seq_q[0] |=> left_bits_q[NBITS-1] == $past(cmp_left_keep_i);
	endproperty
	a_latch_left: assert property (p_latch_left) else $error("msb decision lost");

	// Right bank must not lag the left one
	property p_latch_right;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			seq_q[0] |=> right_bits_q[NBITS-1] == $past(cmp_right_keep_i);
	endproperty
	a_latch_right: assert property (p_latch_right) else $error("right msb lost");

	// Trial bit switched in as the next stage begins
	property p_trial_on;
		@(posedge sys_clk_i) disable iff (!rstn_i) seq_q[0] |=> left_switch_o.capacitor_weighting_dac[NBITS-2];
	endproperty
	a_trial_on: assert property (p_trial_on) else $error("trial bit not switched in");

	// Kept or rejected MSB reaches the switch as its pulse ends
	property p_apply_left;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			seq_q[0] |=> left_switch_o.capacitor_weighting_dac[NBITS-1] == $past(cmp_left_keep_i);
	endproperty
	a_apply_left: assert property (p_apply_left) else $error("msb not applied");

	// Right bank applies its decision on the same edge
	property p_apply_right;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			seq_q[0] |=> right_switch_o.capacitor_weighting_dac[NBITS-1] == $past(cmp_right_keep_i);
	endproperty
	a_apply_right: assert property (p_apply_right) else $error("right msb not applied");

	// Right stream one clock behind its own comparator, with valid high
	property p_serial_delay;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			(|seq_q[NBITS-1:0]) |=> right_serial_out_o == $past(cmp_right_keep_i) && data_valid_o;
	endproperty
	a_serial_delay: assert property (p_serial_delay) else $error("serial out not one clock");

	// Left stream has its own path, independent of the right
	property p_serial_left;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			(|seq_q[NBITS-1:0]) |=> left_serial_out_o == $past(cmp_left_keep_i);
	endproperty
	a_serial_left: assert property (p_serial_left) else $error("left serial late");

	// Valid drops outside the bit tests, so the receiver never overcounts
	property p_valid_off;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			!(|seq_q[NBITS-1:0]) |=> !data_valid_o;
	endproperty
	a_valid_off: assert property (p_valid_off) else $error("valid outside bit tests");

	// Trim switch follows its main switch
	property p_trim_follow;
		@(posedge sys_clk_i) disable iff (!rstn_i)
			left_switch_o.capacitor_weighting_dac == left_switch_o.trim_correction_dac && right_switch_o.capacitor_weighting_dac == right_switch_o.trim_correction_dac;
	endproperty
	a_trim_follow: assert property (p_trim_follow) else $error("trim switch diverged");

	// Main scenarios
	c_start: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) start);
	c_done: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) busy_o ##1 !busy_o);
	c_keep_msb: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
		seq_q[0] && cmp_left_keep_i);
	c_refused: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
		busy_o && convert_i && !conv_prev_q);
endmodule

// ==== sim/dss_far_model.sv ====
// Far-side model of one channel: comparator answer and serial word receiver.
// Assumes the sequencer clock and reset; one instance per channel.
`timescale 1ns/10ps
module dss_far_model
	import dss_pkg::*;
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 rstn_i,
	input  wire logic [DSS_NBITS-1:0] trial_i,
	input  wire logic [DSS_NBITS-1:0] target_i,
	input  wire logic                 valid_i,
	input  wire logic                 serial_i,
	output logic                      keep_o,
	output logic [DSS_NBITS-1:0]      word_o,
	output int                        nbits_o
);
	// ********************
	// Comparator and receiver
	// ********************
	// Keep while the trial does not exceed the held input
	assign keep_o = (trial_i <= target_i);
	// Rising-edge capture, MSB first; count spans all conversions
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_o  <= '0;
			nbits_o <= 0;
		end else if (valid_i) begin
			word_o  <= {word_o[DSS_NBITS-2:0], serial_i};
			nbits_o <= nbits_o + 1;
		end
	end
endmodule

// ==== sim/test_dual_sar_conversion_sequencer.sv ====
// Self-checking bench for the dual conversion sequencer.
// Assumes the far-side model file; stimulus changes on falling edges.
`timescale 1ns/10ps
module test_dual_sar_conversion_sequencer;
	import dss_pkg::*;
	logic                 sys_clk_i, rstn_i, convert_i, kl, kr, hold, az, busy, sl, sr, dv;
	logic [DSS_NBITS:0]   stage;
	dss_switch_s          lsw, rsw;
	logic [DSS_NBITS-1:0] tl, tr, wl, wr;
	int                   nl, nr, err_total, n_tests, cyc;
	// ********************
	// Instances
	// ********************
	dss_sequencer DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .convert_i(convert_i),
		.cmp_left_keep_i(kl), .cmp_right_keep_i(kr), .hold_o(hold), .autozero_o(az),
		.busy_o(busy), .stage_o(stage), .left_switch_o(lsw), .right_switch_o(rsw),
		.left_serial_out_o(sl), .right_serial_out_o(sr), .data_valid_o(dv));
	dss_far_model far_l (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .trial_i(lsw.capacitor_weighting_dac),
		.target_i(tl), .valid_i(dv), .serial_i(sl), .keep_o(kl), .word_o(wl), .nbits_o(nl));
	dss_far_model far_r (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .trial_i(rsw.capacitor_weighting_dac),
		.target_i(tr), .valid_i(dv), .serial_i(sr), .keep_o(kr), .word_o(wr), .nbits_o(nr));
	// ********************
	// Clock, checks, timeout
	// ********************
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Ceiling well above the roughly 90 cycles the tests need
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			summarize();
		end
	end
	// One conversion; poke raises the trigger again mid-conversion
	task automatic conv(input logic [17:0] l, input logic [17:0] r, input bit poke);
		int n, b0;
		b0 = nl;
		tl = l;
		tr = r;
		@(negedge sys_clk_i) convert_i = 1'b1;
		@(negedge sys_clk_i) convert_i = 1'b0;
		chk(18'({hold, az, busy}), 18'h5);
		chk(18'(stage == 19'h00001), 18'h1);
		chk(lsw.capacitor_weighting_dac, 18'h20000);
		chk(lsw.trim_correction_dac, lsw.capacitor_weighting_dac);
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			chk(18'($onehot(stage)), 18'h1);
			chk(18'({hold, az}), 18'h2);
			chk(lsw.trim_correction_dac, lsw.capacitor_weighting_dac);
			chk(rsw.trim_correction_dac, rsw.capacitor_weighting_dac);
			if (poke && n == 5)
				convert_i = 1'b1;
			@(negedge sys_clk_i) n++;
		end
		convert_i = 1'b0;
		chk(18'(n), 18'd19);
		chk(wl, l);
		chk(wr, r);
		chk(18'(nl - b0), 18'd18);
		chk(18'(nr - nl), 18'd0);
		chk(18'({hold, az, busy, dv}), 18'h4);
		$display("Conversion %h %h done", l, r);
	endtask
	// ********************
	// Main sequence
	// ********************
	initial begin
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		rstn_i = 1'b0;
		convert_i = 1'b0;
		tl = '0;
		tr = '0;
		repeat (2) @(negedge sys_clk_i);
		chk(18'({hold, az, busy, dv}), 18'h4);
		chk(18'(stage == 19'h00000), 18'h1);
		rstn_i = 1'b1;
		$display("Reset test done");
		conv(18'h00000, 18'h3ffff, 1'b0);
		conv(18'h2aaaa, 18'h15555, 1'b0);
		conv(18'h1ffff, 18'h20000, 1'b1);
		conv(18'h00001, 18'h3fffe, 1'b0);
		summarize();
	end
endmodule
